// *** hw/supervisor_pkg.sv ***
// Purpose: Shared constants and carriers of the power supervisor logic.
// Assumes: 200 MHz core clock.
// Notes: Register offsets are byte addresses on the serial bus.
package supervisor_pkg;
    localparam int CLK_PERIOD_PS = 5000;
    localparam int RESET_DELAY_MS_PER_NF = 100;
    localparam int RESET_CAP_NF = 1;
    localparam int DEBOUNCE_MS = 30;
    localparam longint PS_PER_MS = 64'd1_000_000_000;
    localparam longint RESET_DELAY_CYCLES =
        RESET_CAP_NF * RESET_DELAY_MS_PER_NF * PS_PER_MS / CLK_PERIOD_PS;
    localparam longint DEBOUNCE_CYCLES =
        DEBOUNCE_MS * PS_PER_MS / CLK_PERIOD_PS;

    localparam logic [6:0] SLAVE_ADDR = 7'h48;
    localparam logic [7:0] REG_REVISION = 8'h00;
    localparam logic [7:0] REG_RAIL_FAULT_STATUS = 8'h01;
    localparam logic [7:0] REG_MASK = 8'h02;
    localparam logic [7:0] REG_LINREG_SEL = 8'h06;
    localparam logic [7:0] UNMAPPED_DATA = 8'hFF;
    localparam logic [7:0] MASK_RESET = 8'hC0;
    localparam logic [7:0] MASK_WRITABLE = 8'hFE;
    localparam int SUPPLY_FAIL_BIT = 7;
    localparam int BATTERY_LOW_BIT = 6;
    localparam int RAIL_LSB = 1;
    localparam int MEMORY_BUCK_IDX = 2;
    localparam int NUM_RAILS = 5;

    typedef struct packed {
        logic scl;
        logic sda;
        logic warm_reset_n;
        logic backup_rail_ok;
        logic supply_fail_sense;
        logic battery_low_sense;
        logic dvt_active;
        logic core_buck_default_sel;
        logic [1:0] linreg_default_sel;
        logic [NUM_RAILS-1:0] rail_low;
        logic [NUM_RAILS-1:0] rail_en;
    } pins_type;

    // Idle bus and released warm reset, so no false start after reset
    localparam pins_type PINS_IDLE = '{scl: 1'b1, sda: 1'b1,
        warm_reset_n: 1'b1, default: '0};

    typedef struct packed {
        logic rd;
        logic wr;
        logic [7:0] ptr;
        logic [7:0] wdata;
    } reg_req_type;
endpackage : supervisor_pkg

// *** hw/pin_sync.sv ***
// Purpose: Three-stage pin synchroniser with agreement filter.
// Assumes: Inputs asynchronous to clk_i.
// Notes: Output follows only when stages two and three agree.
`timescale 1ns/1ps
module pin_sync #(
    parameter int W = 1,
    parameter logic [W-1:0] RST_VAL = '0
) (
    input wire logic clk_i,
    input wire logic rstn_i,
    input wire logic [W-1:0] din_i,
    output logic [W-1:0] dout_o
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
        logic [W-1:0] s3;
        logic [W-1:0] q;
    } sync_state_type;

    sync_state_type r, next_r;

    if (W < 1) begin : g_check
        $error("pin_sync width must be positive");
    end

    always_comb begin
        next_r = r;
        next_r.s1 = din_i;
        next_r.s2 = r.s1;
        next_r.s3 = r.s2;
        // Stage one feeds only stage two; metastability stays contained
        next_r.q = (r.s2 & ~(r.s2 ^ r.s3)) | (r.q & (r.s2 ^ r.s3));
    end

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            r <= '{s1: RST_VAL, s2: RST_VAL, s3: RST_VAL, q: RST_VAL};
        end else begin
            r <= next_r;
        end
    end

    assign dout_o = r.q;
endmodule : pin_sync

// *** hw/i2c_reg_slave.sv ***
// Purpose: Oversampled serial slave with register pointer.
// Assumes: scl_i and sda_i already synchronised; no clock stretching.
// Notes: Read data is sampled from rdata_i when rd pulses.
`timescale 1ns/1ps
module i2c_reg_slave
    import supervisor_pkg::*;
(
    input wire logic clk_i,
    input wire logic rstn_i,
    input wire logic scl_i,
    input wire logic sda_i,
    input wire logic [7:0] rdata_i,
    output logic sda_oe_o,
    output supervisor_pkg::reg_req_type req_o
);
    typedef enum logic [3:0] {
        IDLE, ADDR, ACK_ADDR, PTR, ACK_PTR, WDATA, ACK_DATA, RDATA, RACK
    } slave_st_type;

    typedef struct packed {
        slave_st_type st;
        logic [7:0] sh;
        logic [3:0] cnt;
        logic rw;
        logic ack;
        logic oe;
        logic scl_q;
        logic sda_q;
        reg_req_type req;
    } slave_state_type;

    slave_state_type r, next_r;
    logic start, stop, rise, fall;

    assign start = r.scl_q && scl_i && r.sda_q && !sda_i;
    assign stop = r.scl_q && scl_i && !r.sda_q && sda_i;
    assign rise = !r.scl_q && scl_i;
    assign fall = r.scl_q && !scl_i;

    always_comb begin
        next_r = r;
        next_r.scl_q = scl_i;
        next_r.sda_q = sda_i;
        next_r.req.rd = 1'b0;
        next_r.req.wr = 1'b0;
        if (start) begin
            next_r.st = ADDR;
            next_r.cnt = 4'h0;
            next_r.oe = 1'b0;
        end else if (stop) begin
            next_r.st = IDLE;
            next_r.oe = 1'b0;
        end else if (rise) begin
            case (r.st)
                ADDR, PTR, WDATA: begin
                    next_r.sh = {r.sh[6:0], sda_i};
                    next_r.cnt = r.cnt + 4'h1;
                end
                RDATA: next_r.cnt = r.cnt + 4'h1;
                RACK: next_r.ack = !sda_i;
                default: next_r.st = r.st;
            endcase
        end else if (fall) begin
            case (r.st)
                ADDR: begin
                    if (r.cnt == 4'h8) begin
                        if (r.sh[7:1] == SLAVE_ADDR) begin
                            next_r.rw = r.sh[0];
                            next_r.oe = 1'b1;
                            next_r.st = ACK_ADDR;
                        end else begin
                            next_r.st = IDLE;
                        end
                    end
                end
                ACK_ADDR, RACK: begin
                    next_r.cnt = 4'h0;
                    if ((r.st == ACK_ADDR && r.rw) ||
                        (r.st == RACK && r.ack)) begin
                        next_r.sh = rdata_i;
                        next_r.oe = !rdata_i[7];
                        next_r.req.rd = 1'b1;
                        next_r.st = RDATA;
                    end else if (r.st == ACK_ADDR) begin
                        next_r.oe = 1'b0;
                        next_r.st = PTR;
                    end else begin
                        next_r.oe = 1'b0;
                        next_r.st = IDLE;
                    end
                end
                PTR, WDATA: begin
                    if (r.cnt == 4'h8) begin
                        next_r.oe = 1'b1;
                        if (r.st == PTR) begin
                            next_r.req.ptr = r.sh;
                            next_r.st = ACK_PTR;
                        end else begin
                            next_r.req.wdata = r.sh;
                            next_r.req.wr = 1'b1;
                            next_r.st = ACK_DATA;
                        end
                    end
                end
                ACK_PTR, ACK_DATA: begin
                    next_r.oe = 1'b0;
                    next_r.cnt = 4'h0;
                    next_r.st = WDATA;
                end
                RDATA: begin
                    if (r.cnt == 4'h8) begin
                        next_r.oe = 1'b0;
                        next_r.st = RACK;
                    end else begin
                        next_r.sh = {r.sh[6:0], 1'b1};
                        next_r.oe = !r.sh[6];
                    end
                end
                default: next_r.st = IDLE;
            endcase
        end
    end

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            r <= '{st: IDLE, scl_q: 1'b1, sda_q: 1'b1, default: '0};
        end else begin
            r <= next_r;
        end
    end

    assign sda_oe_o = r.oe;
    assign req_o = r.req;
endmodule : i2c_reg_slave

// *** hw/pmic_supervisor.sv ***
// Purpose: Reset, power-good, default latching and status registers.
// Assumes: Analog comparators deliver digital levels; RSTN_I is the
//          undervoltage lockout.
// Notes: Timing counts are parameters so simulation can shorten them.
`timescale 1ns/1ps
module pmic_supervisor
    import supervisor_pkg::*;
#(
    parameter int unsigned RESET_CYCLES = int'(RESET_DELAY_CYCLES),
    parameter int unsigned DEBOUNCE_LEN = int'(DEBOUNCE_CYCLES),
    // Arbitrary value, not tied to any real part
    parameter logic [7:0] REVISION_CODE = 8'h5A
) (
    input wire logic CLK_I,
    input wire logic RSTN_I,
    input wire logic SCL_I,
    input wire logic SDA_I,
    output logic SDA_O,
    output logic SDA_OE_O,
    input wire logic WARM_RESET_N_I,
    input wire logic BACKUP_RAIL_OK_I,
    input wire logic SUPPLY_FAIL_SENSE_I,
    input wire logic BATTERY_LOW_SENSE_I,
    input wire logic DVT_ACTIVE_I,
    input wire logic CORE_BUCK_DEFAULT_SEL_I,
    input wire logic [1:0] LINREG_DEFAULT_SEL_I,
    input wire logic [supervisor_pkg::NUM_RAILS-1:0] RAIL_LOW_I,
    input wire logic [supervisor_pkg::NUM_RAILS-1:0] RAIL_EN_I,
    output logic SYSTEM_RESET_N_O,
    output logic SYSTEM_RESET_N_OE_O,
    output logic INT_N_O,
    output logic INT_N_OE_O,
    output logic CORE_BUCK_RELOAD_O,
    output logic CORE_BUCK_DEFAULT_SEL_O,
    output logic [1:0] LINREG_SEL_O
);
    import supervisor_pkg::*;

    typedef struct packed {
        logic [31:0] db_cnt;
        logic warm_active;
        logic [31:0] rst_cnt;
        logic sys_rst_n;
        logic reload;
        logic core_sel;
        logic [7:0] mask;
        logic [1:0] linreg_sel;
        logic sel_taken;
        logic int_quiet;
        logic int_low;
        logic [7:0] fault_q;
    } top_state_type;

    top_state_type r, next_r;
    pins_type pins_raw, pins;
    reg_req_type req;
    logic [7:0] status;
    logic [7:0] unmasked;
    logic [7:0] rdata;
    logic [NUM_RAILS-1:0] rail_fault;
    logic none_enabled;
    logic warm_raw_active;

    if (RESET_CYCLES < 1 || DEBOUNCE_LEN < 1) begin : g_check
        $error("timing counts must be at least one cycle");
    end

    assign pins_raw = '{scl: SCL_I, sda: SDA_I,
        warm_reset_n: WARM_RESET_N_I, backup_rail_ok: BACKUP_RAIL_OK_I,
        supply_fail_sense: SUPPLY_FAIL_SENSE_I,
        battery_low_sense: BATTERY_LOW_SENSE_I,
        dvt_active: DVT_ACTIVE_I,
        core_buck_default_sel: CORE_BUCK_DEFAULT_SEL_I,
        linreg_default_sel: LINREG_DEFAULT_SEL_I,
        rail_low: RAIL_LOW_I, rail_en: RAIL_EN_I};

    pin_sync #(
        .W($bits(pins_type)),
        .RST_VAL(PINS_IDLE)
    ) u_sync (
        .clk_i(CLK_I),
        .rstn_i(RSTN_I),
        .din_i(pins_raw),
        .dout_o(pins)
    );

    i2c_reg_slave u_slave (
        .clk_i(CLK_I),
        .rstn_i(RSTN_I),
        .scl_i(pins.scl),
        .sda_i(pins.sda),
        .rdata_i(rdata),
        .sda_oe_o(SDA_OE_O),
        .req_o(req)
    );

    assign warm_raw_active = !pins.warm_reset_n;

    always_comb begin
        rail_fault = pins.rail_low & pins.rail_en;
        if (pins.dvt_active) begin
            rail_fault[MEMORY_BUCK_IDX] = 1'b0;
        end
    end

    always_comb begin
        status = 8'h00;
        status[SUPPLY_FAIL_BIT] = pins.supply_fail_sense;
        status[BATTERY_LOW_BIT] = pins.battery_low_sense;
        status[RAIL_LSB +: NUM_RAILS] = rail_fault;
    end

    assign unmasked = status & ~r.mask;
    assign none_enabled = (pins.rail_en == '0);

    always_comb begin
        case (req.ptr)
            REG_REVISION: rdata = REVISION_CODE;
            REG_RAIL_FAULT_STATUS: rdata = status;
            REG_MASK: rdata = r.mask;
            REG_LINREG_SEL: rdata = {6'h00, r.linreg_sel};
            default: rdata = UNMAPPED_DATA;
        endcase
    end

    always_comb begin
        next_r = r;

        if (warm_raw_active != r.warm_active) begin
            if (r.db_cnt >= DEBOUNCE_LEN - 1) begin
                next_r.warm_active = warm_raw_active;
                next_r.db_cnt = '0;
            end else begin
                next_r.db_cnt = r.db_cnt + 32'h0000_0001;
            end
        end else begin
            next_r.db_cnt = '0;
        end

        if (!pins.backup_rail_ok || r.warm_active) begin
            next_r.sys_rst_n = 1'b0;
            next_r.rst_cnt = '0;
        end else if (!r.sys_rst_n) begin
            if (r.rst_cnt >= RESET_CYCLES - 1) begin
                next_r.sys_rst_n = 1'b1;
            end else begin
                next_r.rst_cnt = r.rst_cnt + 32'h0000_0001;
            end
        end

        next_r.reload = r.warm_active || !pins.backup_rail_ok ||
            !r.sys_rst_n;
        // only core buck follows warm reset
        if (next_r.reload) begin
            next_r.core_sel = pins.core_buck_default_sel;
        end

        // follow pins until first reset release
        // Synced pins still hold reset values at the first edge
        if (!r.sel_taken) begin
            next_r.sel_taken = r.sys_rst_n;
            next_r.linreg_sel = pins.linreg_default_sel;
        end

        if (req.wr) begin
            if (req.ptr == REG_MASK) begin
                next_r.mask = req.wdata & MASK_WRITABLE;
            end
            if (req.ptr == REG_LINREG_SEL) begin
                next_r.linreg_sel = req.wdata[1:0];
            end
        end

        if (req.rd && req.ptr == REG_RAIL_FAULT_STATUS && r.int_low) begin
            next_r.int_quiet = 1'b1;
        end
        // new fault re-arms, wins over read
        if (|(unmasked & ~r.fault_q)) begin
            next_r.int_quiet = 1'b0;
        end
        next_r.fault_q = unmasked;

        // low while an unmasked fault is not yet read, or while no rail is enabled
        next_r.int_low = none_enabled ||
            ((|unmasked) && !next_r.int_quiet);
    end

    always_ff @(posedge CLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            r <= '{mask: MASK_RESET, reload: 1'b1, int_low: 1'b1,
                default: '0};
        end else begin
            r <= next_r;
        end
    end

    // Open-drain pins drive only low
    assign SDA_O = 1'b0;
    assign SYSTEM_RESET_N_O = 1'b0;
    assign SYSTEM_RESET_N_OE_O = !r.sys_rst_n;
    assign INT_N_O = 1'b0;
    assign INT_N_OE_O = r.int_low;
    assign CORE_BUCK_RELOAD_O = r.reload;
    assign CORE_BUCK_DEFAULT_SEL_O = r.core_sel;
    assign LINREG_SEL_O = r.linreg_sel;
endmodule : pmic_supervisor

// *** verification/pmic_supervisor_properties.sv ***
// Purpose: Port checks of the power supervisor.
// Assumes: Short counts in test; pin sync latency up to eight cycles.
// Notes: Counters track how long inputs have held their level.
`timescale 1ns/1ps
module pmic_supervisor_properties
    import supervisor_pkg::*;
#(
    parameter int unsigned RESET_CYCLES = 20,
    parameter int unsigned DEBOUNCE_LEN = 10
) (
    input wire logic CLK_I,
    input wire logic RSTN_I,
    input wire logic SCL_I,
    input wire logic WARM_RESET_N_I,
    input wire logic BACKUP_RAIL_OK_I,
    input wire logic SUPPLY_FAIL_SENSE_I,
    input wire logic BATTERY_LOW_SENSE_I,
    input wire logic [supervisor_pkg::NUM_RAILS-1:0] RAIL_LOW_I,
    input wire logic [supervisor_pkg::NUM_RAILS-1:0] RAIL_EN_I,
    input wire logic SDA_OE_O,
    input wire logic SYSTEM_RESET_N_OE_O,
    input wire logic INT_N_OE_O,
    input wire logic CORE_BUCK_RELOAD_O
);
    int unsigned bk_cnt;
    int unsigned ok_cnt;
    int unsigned low_cnt;
    always_ff @(posedge CLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            bk_cnt <= 0;
            ok_cnt <= 0;
            low_cnt <= 0;
        end else begin
            bk_cnt <= BACKUP_RAIL_OK_I ? bk_cnt + 1 : 0;
            ok_cnt <= (BACKUP_RAIL_OK_I && WARM_RESET_N_I) ? ok_cnt + 1 : 0;
            low_cnt <= WARM_RESET_N_I ? 0 : low_cnt + 1;
        end
    end
    default clocking cb @(posedge CLK_I); endclocking
    default disable iff (!RSTN_I);
    a_reset_backup_low: assert property (
        !BACKUP_RAIL_OK_I [*8] |-> SYSTEM_RESET_N_OE_O)
        else $error("reset not held with backup rail low");
    a_reset_min_hold: assert property (
        $fell(SYSTEM_RESET_N_OE_O) |-> bk_cnt >= RESET_CYCLES)
        else $error("reset released too early");
    a_reset_max_hold: assert property (
        ok_cnt >= DEBOUNCE_LEN + RESET_CYCLES + 12 |-> !SYSTEM_RESET_N_OE_O)
        else $error("reset released too late");
    a_warm_triggers_reset: assert property (
        low_cnt >= DEBOUNCE_LEN + 8 |-> SYSTEM_RESET_N_OE_O)
        else $error("warm reset did not assert reset");
    a_reload_in_reset: assert property (
        SYSTEM_RESET_N_OE_O && $past(SYSTEM_RESET_N_OE_O)
        && $past(SYSTEM_RESET_N_OE_O, 2) |-> CORE_BUCK_RELOAD_O)
        else $error("core buck not reloaded in reset");
    a_int_no_rail: assert property (
        RAIL_EN_I == '0 [*8] |-> INT_N_OE_O)
        else $error("interrupt released with no rail enabled");
    a_int_all_ok: assert property (
        (RAIL_EN_I != '0 && (RAIL_LOW_I & RAIL_EN_I) == '0
        && !SUPPLY_FAIL_SENSE_I && !BATTERY_LOW_SENSE_I) [*8]
        |-> !INT_N_OE_O)
        else $error("interrupt low with all rails good");
    a_sda_stable_high: assert property (
        $changed(SDA_OE_O) |-> !SCL_I)
        else $error("data line moved while clock high");
endmodule : pmic_supervisor_properties
bind pmic_supervisor pmic_supervisor_properties #(
    .RESET_CYCLES(RESET_CYCLES),
    .DEBOUNCE_LEN(DEBOUNCE_LEN)
) pmic_supervisor_properties_i (
    .CLK_I(CLK_I),
    .RSTN_I(RSTN_I),
    .SCL_I(SCL_I),
    .WARM_RESET_N_I(WARM_RESET_N_I),
    .BACKUP_RAIL_OK_I(BACKUP_RAIL_OK_I),
    .SUPPLY_FAIL_SENSE_I(SUPPLY_FAIL_SENSE_I),
    .BATTERY_LOW_SENSE_I(BATTERY_LOW_SENSE_I),
    .RAIL_LOW_I(RAIL_LOW_I),
    .RAIL_EN_I(RAIL_EN_I),
    .SDA_OE_O(SDA_OE_O),
    .SYSTEM_RESET_N_OE_O(SYSTEM_RESET_N_OE_O),
    .INT_N_OE_O(INT_N_OE_O),
    .CORE_BUCK_RELOAD_O(CORE_BUCK_RELOAD_O)
);

// *** verification/i2c_host_model.sv ***
// Purpose: Serial bus master standing in for the host processor.
// Assumes: Pull-up on the data line; slave never stretches the clock.
// Notes: Clock stands still between frames; 30 ns low, 18 ns high.
`timescale 1ns/1ps
module i2c_host_model (
    input wire logic sda_i,
    output logic scl_o,
    output logic sda_oe_o
);
    initial begin
        scl_o = 1'b1;
        sda_oe_o = 1'b0;
    end
    // 48 ns bit period
    // Data moves 10 ns after the fall so it never races the clock sync
    task automatic bit_io(input logic b, output logic r);
        #10 sda_oe_o = ~b;
        #20 scl_o = 1'b1;
        #17 r = sda_i;
        #1 scl_o = 1'b0;
    endtask : bit_io
    // Long wait lets the slave drop its acknowledge first
    task automatic start_cond();
        #10 sda_oe_o = 1'b0;
        #30 scl_o = 1'b1;
        #24 sda_oe_o = 1'b1;
        #24 scl_o = 1'b0;
    endtask : start_cond
    task automatic stop_cond();
        #10 sda_oe_o = 1'b1;
        #20 scl_o = 1'b1;
        #24 sda_oe_o = 1'b0;
        #24;
    endtask : stop_cond
    task automatic send(input logic [7:0] d, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_io(d[i], r);
        end
        bit_io(1'b1, r);
        ack = ~r;
    endtask : send
    // last byte not acknowledged, line left released
    task automatic recv(input logic last, output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_io(1'b1, r);
            d[i] = r;
        end
        bit_io(last, r);
    endtask : recv
    task automatic probe(input logic [6:0] a, output logic ack);
        start_cond();
        send({a, 1'b0}, ack);
        stop_cond();
    endtask : probe
    task automatic write_reg(input logic [7:0] p, input logic [7:0] d,
                             output logic ok);
        logic a0, a1, a2;
        start_cond();
        send({7'b1001000, 1'b0}, a0);
        send(p, a1);
        send(d, a2);
        stop_cond();
        ok = a0 & a1 & a2;
    endtask : write_reg
    // pointer is written first, then a repeated start begins the read
    task automatic read_reg(input logic [7:0] p, output logic [7:0] d,
                            output logic ok);
        logic a0, a1, a2;
        start_cond();
        send({7'b1001000, 1'b0}, a0);
        send(p, a1);
        start_cond();
        send({7'b1001000, 1'b1}, a2);
        recv(1'b1, d);
        stop_cond();
        ok = a0 & a1 & a2;
    endtask : read_reg
endmodule : i2c_host_model

// *** verification/pmic_supervisor_test.sv ***
// Purpose: Self-checking bench of the power supervisor.
// Assumes: Shortened reset and debounce counts.
// Notes: Status expectations are rebuilt from the pin levels.
`timescale 1ns/1ps
module pmic_supervisor_test;
    import supervisor_pkg::*;
    localparam int unsigned RST_CYC = 20;
    localparam int unsigned DEB_CYC = 10;
    // Arbitrary revision value
    localparam logic [7:0] REV = 8'h3C;
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic warm_n = 1'b1;
    logic backup = 1'b0;
    logic sf = 1'b0;
    logic bl = 1'b0;
    logic dvt = 1'b0;
    logic core_sel = 1'b1;
    logic [1:0] lr_sel = 2'b10;
    logic [NUM_RAILS-1:0] low = '0;
    logic [NUM_RAILS-1:0] en = 5'h1F;
    logic scl, host_oe, sda_oe, sda_o, rs_o, rs_oe, int_o, int_oe;
    logic reload, core_out, ok;
    logic [1:0] lr_out;
    logic [7:0] rd;
    wire sda = ~(host_oe | sda_oe);
    int num_errors = 0;
    int cmp_count = 0;
    int unsigned seed = 28;
    always #2.5 clk = ~clk;
    pmic_supervisor #(.RESET_CYCLES(RST_CYC), .DEBOUNCE_LEN(DEB_CYC),
        .REVISION_CODE(REV)) pmic_supervisor_i (
        .CLK_I(clk), .RSTN_I(rstn), .SCL_I(scl), .SDA_I(sda),
        .SDA_O(sda_o), .SDA_OE_O(sda_oe), .WARM_RESET_N_I(warm_n),
        .BACKUP_RAIL_OK_I(backup), .SUPPLY_FAIL_SENSE_I(sf),
        .BATTERY_LOW_SENSE_I(bl), .DVT_ACTIVE_I(dvt),
        .CORE_BUCK_DEFAULT_SEL_I(core_sel), .LINREG_DEFAULT_SEL_I(lr_sel),
        .RAIL_LOW_I(low), .RAIL_EN_I(en), .SYSTEM_RESET_N_O(rs_o),
        .SYSTEM_RESET_N_OE_O(rs_oe), .INT_N_O(int_o), .INT_N_OE_O(int_oe),
        .CORE_BUCK_RELOAD_O(reload), .CORE_BUCK_DEFAULT_SEL_O(core_out),
        .LINREG_SEL_O(lr_out));
    i2c_host_model i2c_host_model_i (.sda_i(sda), .scl_o(scl),
        .sda_oe_o(host_oe));
    function automatic logic [7:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed[7:0];
    endfunction : rnd
    // Bit 3 is the memory buck, zero during a voltage transition
    function automatic logic [7:0] status_exp();
        logic [4:0] f;
        f = low & en;
        if (dvt) f[2] = 1'b0;
        return {sf, bl, f, 1'b0};
    endfunction : status_exp
    task automatic check(input logic [7:0] got, input logic [7:0] exp,
                         input string what);
        cmp_count++;
        if (got !== exp) begin
            num_errors++;
            $display("unexpected at %0t: %s %h not %h", $time, what, got, exp);
        end
    endtask : check
    task automatic cyc(input int n);
        repeat (n) @(negedge clk);
    endtask : cyc
    task automatic rd_chk(input logic [7:0] p, input logic [7:0] exp,
                          input string what);
        i2c_host_model_i.read_reg(p, rd, ok);
        check({7'b0, ok}, 8'h01, "ack");
        check(rd, exp, what);
    endtask : rd_chk
    task automatic wr(input logic [7:0] p, input logic [7:0] d);
        i2c_host_model_i.write_reg(p, d, ok);
        check({7'b0, ok}, 8'h01, "ack");
    endtask : wr
    task automatic wait_release(output int n);
        n = 0;
        while (rs_oe !== 1'b0 && n < 200) begin
            cyc(1);
            n++;
        end
        check({7'b0, rs_oe}, 8'h00, "reset release");
    endtask : wait_release
    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
        if (num_errors == 0 && cmp_count > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : end_of_test
    initial begin
        #400_000;
        num_errors++;
        $display("unexpected at %0t: watchdog", $time);
        end_of_test();
    end
    initial begin
        int n;
        cyc(16);
        rstn = 1'b1;
        cyc(40);
        check({7'b0, rs_oe}, 8'h01, "reset low");
        backup = 1'b1;
        cyc(RST_CYC);
        check({7'b0, rs_oe}, 8'h01, "reset hold");
        wait_release(n);
        check({7'b0, n <= 12}, 8'h01, "reset delay");
        cyc(2);
        check({7'b0, reload}, 8'h00, "reload off");
        check({7'b0, core_out}, 8'h01, "core default");
        check({6'b0, lr_out}, 8'h02, "linreg latch");
        check({5'b0, sda_o, rs_o, int_o}, 8'h00, "open drain");
        check({7'b0, int_oe}, 8'h00, "power ok");
        $display("power-up test done");
        rd_chk(REG_REVISION, REV, "revision");
        wr(REG_REVISION, 8'h00);
        rd_chk(REG_REVISION, REV, "revision ro");
        rd_chk(REG_MASK, 8'hC0, "mask reset");
        rd_chk(8'h10, 8'hFF, "unmapped");
        i2c_host_model_i.probe(7'h49, ok);
        check({7'b0, ok}, 8'h00, "other address");
        for (int i = 0; i < 4; i++) begin
            wr(REG_LINREG_SEL, 8'(i));
            check({6'b0, lr_out}, 8'(i), "linreg select");
        end
        for (int i = 0; i < 6; i++) begin
            @(negedge clk);
            {sf, bl, dvt, low} = rnd();
            en = 5'(rnd());
            cyc(10);
            rd_chk(REG_RAIL_FAULT_STATUS, status_exp(), "status");
        end
        $display("register test done");
        {sf, bl, dvt, low, en} = {3'b000, 5'h00, 5'h1F};
        cyc(10);
        check({7'b0, int_oe}, 8'h00, "int idle");
        low = 5'h04;
        cyc(10);
        check({7'b0, int_oe}, 8'h01, "int fault");
        rd_chk(REG_RAIL_FAULT_STATUS, 8'h08, "fault bit");
        cyc(4);
        check({7'b0, int_oe}, 8'h00, "int quiet");
        low = 5'h05;
        cyc(10);
        check({7'b0, int_oe}, 8'h01, "int rearm");
        low = 5'h00;
        cyc(10);
        check({7'b0, int_oe}, 8'h00, "int recover");
        wr(REG_MASK, 8'h02);
        low = 5'h01;
        cyc(10);
        check({7'b0, int_oe}, 8'h00, "int masked");
        en = 5'h00;
        cyc(10);
        check({7'b0, int_oe}, 8'h01, "no rail");
        {low, en} = {5'h00, 5'h1F};
        $display("interrupt test done");
        warm_n = 1'b0;
        cyc(5);
        warm_n = 1'b1;
        cyc(20);
        check({7'b0, rs_oe}, 8'h00, "glitch ignored");
        core_sel = 1'b0;
        warm_n = 1'b0;
        cyc(DEB_CYC + 10);
        check({7'b0, rs_oe}, 8'h01, "warm reset");
        check({7'b0, reload}, 8'h01, "warm reload");
        check({7'b0, core_out}, 8'h00, "reload value");
        warm_n = 1'b1;
        cyc(DEB_CYC + RST_CYC);
        wait_release(n);
        rd_chk(REG_MASK, 8'h02, "mask kept");
        backup = 1'b0;
        cyc(10);
        check({7'b0, rs_oe}, 8'h01, "backup drop");
        check({7'b0, reload}, 8'h01, "backup reload");
        backup = 1'b1;
        cyc(RST_CYC);
        wait_release(n);
        $display("reset test done");
        end_of_test();
    end
endmodule : pmic_supervisor_test
